// *** shared/tbpwm_pkg.sv ***
/*
 Package for the timer based pulse output block: register offsets, field
 positions, reset values and mode codes. Assumes a 32-bit APB register bus.
*/
package tbpwm_pkg;
   localparam logic [7:0] TBPWM_OFF_TIMER_COUNT = 8'h00;
   localparam logic [7:0] TBPWM_OFF_PERIOD = 8'h04;
   localparam logic [7:0] TBPWM_OFF_TIMER_CTRL = 8'h08;
   localparam logic [7:0] TBPWM_OFF_DUTY_LOW = 8'h0c;
   localparam logic [7:0] TBPWM_OFF_DUTY_BUF = 8'h10;
   localparam logic [7:0] TBPWM_OFF_CHAN_CTRL = 8'h14;
   localparam logic [7:0] TBPWM_OFF_FLAGS = 8'h18;
   localparam logic [7:0] TBPWM_RST_TIMER_COUNT = 8'h00;
   localparam logic [7:0] TBPWM_RST_PERIOD = 8'hff;
   localparam logic [6:0] TBPWM_RST_TIMER_CTRL = 7'h00;
   localparam logic [7:0] TBPWM_RST_DUTY = 8'h00;
   localparam logic [5:0] TBPWM_RST_CHAN_CTRL = 6'h00;
   localparam int TBPWM_TCTL_PRESCALE_LSB = 0;
   localparam int TBPWM_TCTL_ON_BIT = 2;
   localparam int TBPWM_TCTL_POST_LSB = 3;
   localparam int TBPWM_CCTL_MODE_LSB = 0;
   localparam int TBPWM_CCTL_DUTY_LSB = 4;
   localparam int TBPWM_FLAG_TIMER_BIT = 1;
   localparam int TBPWM_FLAG_CHAN_BIT = 2;
   localparam logic [1:0] TBPWM_PRESCALE_DIV1 = 2'h0;
   localparam logic [1:0] TBPWM_PRESCALE_DIV4 = 2'h1;
   localparam logic [1:0] TBPWM_PRESCALE_DIV16_SEL = 2'h2;
   localparam logic [3:0] TBPWM_MODE_PULSE_A = 4'hc;
   localparam logic [1:0] TBPWM_QTR_RST = 2'h0;
endpackage : tbpwm_pkg

// *** core/tbpwm_top.sv ***
/*
 Pulse width output for channel one, timed by an 8-bit period timer with a
 1/4/16 prescaler and a 4-bit postscaler. Registers reached over APB.
 Assumes a single clock; the instruction cycle is four clk cycles.
*/
`timescale 1ns/1ps
module tbpwm_top
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pulse_output_pin
);
   import tbpwm_pkg::*;

   // Prescaler
   logic [1:0] qtr_reg;
   logic [1:0] qtr_next;
   logic [3:0] pre_reg;
   logic [3:0] pre_next;
   // Period timer and postscaler
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [3:0] post_reg;
   logic [3:0] post_next;
   // Timer flag
   logic flag_reg;
   logic flag_next;
   // Duty double buffer
   logic [7:0] duty_buf_reg;
   logic [7:0] duty_buf_next;
   logic [1:0] duty_lat_reg;
   logic [1:0] duty_lat_next;
   // Output latch
   logic out_reg;
   logic out_next;
   // Software settings
   logic [7:0] period_reg;
   logic [7:0] period_next;
   logic [6:0] tctl_reg;
   logic [6:0] tctl_next;
   logic [7:0] duty_low_reg;
   logic [7:0] duty_low_next;
   logic [5:0] cctl_reg;
   logic [5:0] cctl_next;
   // Read data
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   logic wr_en;
   logic rd_setup;
   logic pulse_mode;
   logic tick;
   logic match;
   logic restart;
   logic post_done;
   logic [1:0] low_bits;
   logic [9:0] duty_buf_full;
   logic [9:0] duty_new;

   assign wr_en = psel & penable & pwrite;
   // Read data is fetched in the setup cycle so it stands through the access cycle
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = rdata_reg;
   assign pulse_output_pin = out_reg;
   assign pulse_mode = (cctl_reg[TBPWM_CCTL_MODE_LSB +: 4] & TBPWM_MODE_PULSE_A)
                       == TBPWM_MODE_PULSE_A;
   assign duty_buf_full = {duty_buf_reg, duty_lat_reg};
   assign duty_new = {duty_low_reg, cctl_reg[TBPWM_CCTL_DUTY_LSB +: 2]};
   assign match = (count_reg == period_reg);
   assign restart = tick & match;
   assign post_done = restart && (post_reg == tctl_reg[TBPWM_TCTL_POST_LSB +: 4]);

   // Timer increment: prescaled instruction cycle
   always_comb
   begin
      qtr_next = qtr_reg + 2'h1;
      pre_next = pre_reg;
      tick = 1'b0;
      if (tctl_reg[TBPWM_TCTL_ON_BIT] && qtr_reg == 2'h3)
      begin
         pre_next = pre_reg + 4'h1;
         if (tctl_reg[1:0] == TBPWM_PRESCALE_DIV1)
            tick = 1'b1;
         else if (tctl_reg[1:0] == TBPWM_PRESCALE_DIV4)
            tick = (pre_reg[1:0] == 2'h3);
         else
            tick = (pre_reg == 4'hf);
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         qtr_reg <= TBPWM_QTR_RST;
         pre_reg <= 4'h0;
      end
      else
      begin
         qtr_reg <= qtr_next;
         pre_reg <= pre_next;
      end
   end

   // Extra comparison bits of the coming cycle: comparing ahead lets the pin
   // fall on the very edge at which the time base reaches the duty value
   always_comb
   begin
      if (tctl_reg[1:0] == TBPWM_PRESCALE_DIV1)
         low_bits = qtr_next;
      else if (tctl_reg[1:0] == TBPWM_PRESCALE_DIV4)
         low_bits = pre_next[1:0];
      else
         low_bits = pre_next[3:2];
   end

   // Period timer and postscaler
   always_comb
   begin
      count_next = count_reg;
      post_next = post_reg;
      if (tick)
         count_next = match ? 8'h00 : count_reg + 8'h01;
      if (restart)
      begin
         // Postscaler counts periods for the flag only, never for the period
         post_next = post_reg + 4'h1;
         if (post_done)
            post_next = 4'h0;
      end
      // A software write to the count wins over the increment
      if (wr_en && paddr == TBPWM_OFF_TIMER_COUNT)
         count_next = pwdata[7:0];
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_reg <= TBPWM_RST_TIMER_COUNT;
         post_reg <= 4'h0;
      end
      else
      begin
         count_reg <= count_next;
         post_reg <= post_next;
      end
   end

   // Timer flag, write one to clear
   always_comb
   begin
      flag_next = flag_reg;
      if (wr_en && paddr == TBPWM_OFF_FLAGS && pwdata[TBPWM_FLAG_TIMER_BIT])
         flag_next = 1'b0;
      // Hardware set wins over a clear in the same cycle, so no period is lost
      if (post_done)
         flag_next = 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flag_reg <= 1'b0;
      else
         flag_reg <= flag_next;
   end

   // Duty double buffer
   always_comb
   begin
      duty_buf_next = duty_buf_reg;
      duty_lat_next = duty_lat_reg;
      if (restart)
      begin
         duty_buf_next = duty_low_reg;
         duty_lat_next = cctl_reg[TBPWM_CCTL_DUTY_LSB +: 2];
      end
      if (wr_en && paddr == TBPWM_OFF_DUTY_BUF && !pulse_mode)
         duty_buf_next = pwdata[7:0];
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         duty_buf_reg <= TBPWM_RST_DUTY;
         duty_lat_reg <= 2'h0;
      end
      else
      begin
         duty_buf_reg <= duty_buf_next;
         duty_lat_reg <= duty_lat_next;
      end
   end

   // Output latch; a duty beyond the period never meets the time base
   always_comb
   begin
      out_next = out_reg;
      if (!pulse_mode)
         out_next = 1'b0;
      else if (restart)
         out_next = (duty_new != 10'h000);
      else if (duty_buf_full == {count_next, low_bits})
         out_next = 1'b0;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         out_reg <= 1'b0;
      else
         out_reg <= out_next;
   end

   // Software settings
   always_comb
   begin
      period_next = period_reg;
      tctl_next = tctl_reg;
      duty_low_next = duty_low_reg;
      cctl_next = cctl_reg;
      if (wr_en)
      begin
         if (paddr == TBPWM_OFF_PERIOD)
            period_next = pwdata[7:0];
         else if (paddr == TBPWM_OFF_TIMER_CTRL)
            tctl_next = pwdata[6:0];
         else if (paddr == TBPWM_OFF_DUTY_LOW)
            duty_low_next = pwdata[7:0];
         else if (paddr == TBPWM_OFF_CHAN_CTRL)
            cctl_next = pwdata[5:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         period_reg <= TBPWM_RST_PERIOD;
         tctl_reg <= TBPWM_RST_TIMER_CTRL;
         duty_low_reg <= TBPWM_RST_DUTY;
         cctl_reg <= TBPWM_RST_CHAN_CTRL;
      end
      else
      begin
         period_reg <= period_next;
         tctl_reg <= tctl_next;
         duty_low_reg <= duty_low_next;
         cctl_reg <= cctl_next;
      end
   end

   // Read data, taken in the setup cycle; the timer may move on during the access
   always_comb
   begin
      rdata_next = rdata_reg;
      if (rd_setup)
      begin
         if (paddr == TBPWM_OFF_TIMER_COUNT)
            rdata_next = {24'h0, count_reg};
         else if (paddr == TBPWM_OFF_PERIOD)
            rdata_next = {24'h0, period_reg};
         else if (paddr == TBPWM_OFF_TIMER_CTRL)
            rdata_next = {25'h0, tctl_reg};
         else if (paddr == TBPWM_OFF_DUTY_LOW)
            rdata_next = {24'h0, duty_low_reg};
         else if (paddr == TBPWM_OFF_DUTY_BUF)
            rdata_next = {24'h0, duty_buf_reg};
         else if (paddr == TBPWM_OFF_CHAN_CTRL)
            rdata_next = {26'h0, cctl_reg};
         else if (paddr == TBPWM_OFF_FLAGS)
            rdata_next = {29'h0, 1'b0, flag_reg, 1'b0};
         else
            rdata_next = 32'h0;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_reg <= 32'h0;
      else
         rdata_reg <= rdata_next;
   end
endmodule : tbpwm_top

// *** bench/tbpwm_sva.sv ***
/* Port checker for tbpwm_top.
 Assumes the zero-wait APB slave and the bind at the foot. */
`timescale 1ns/1ps
module tbpwm_sva
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pulse_output_pin
);
   logic on_reg;
   logic on_next;
   logic rd;
   logic rd_setup;
   logic wr14;
   assign rd = psel && penable && !pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr14 = psel && penable && pwrite && paddr == 8'h14;
   always_comb
   begin
      on_next = on_reg;
      if (wr14)
         on_next = pwdata[3:2] == 2'b11;
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         on_reg <= 1'b0;
      else
         on_reg <= on_next;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ready_high_a: assert property (pready) else $error("pready low");
   no_error_a: assert property (!pslverr) else $error("pslverr high");
   read_hold_a: assert property (!$past(rd_setup) |-> $stable(prdata)) else $error("prdata moved");
   unmapped_zero_a: assert property (rd && paddr == 8'h1c |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   ctrl_clear_a: assert property (wr14 && pwdata[3:2] != 2'b11 |=> ##1 !pulse_output_pin)
      else $error("pin high after clear");
   mode_low_a: assert property ((!on_reg) [*3] |-> !pulse_output_pin)
      else $error("pin high outside pulse mode");
   rise_mode_a: assert property ($rose(pulse_output_pin) |-> on_reg || $past(on_reg))
      else $error("pin rose outside pulse mode");
   rise_space_a: assert property ($rose(pulse_output_pin) |=> (!$rose(pulse_output_pin)) [*3])
      else $error("restarts too close");
   cover property (wr14);
   cover property ($rose(pulse_output_pin));
   cover property (rd && paddr == 8'h1c);
endmodule : tbpwm_sva
bind tbpwm_top tbpwm_sva u_sva (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pulse_output_pin(pulse_output_pin));

// *** bench/testbench.sv ***
/* Self-checking bench for tbpwm_top: APB tasks, register and waveform tests.
 Assumes read data stands at the access edge that completes the transfer. */
`timescale 1ns/1ps
module testbench;
   import tbpwm_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] q;
   logic pready;
   logic pin;
   int error_cnt = 0;
   int checks_done = 0;
   int hi;
   int rises;
   int n;
   int mul [3] = '{1, 4, 16};
   logic [1:0] pre [3] = '{TBPWM_PRESCALE_DIV1, TBPWM_PRESCALE_DIV4, TBPWM_PRESCALE_DIV16_SEL};
   tbpwm_top DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .pulse_output_pin(pin));
   initial
   begin
      forever #25 clk = ~clk;
   end
   task automatic stop_test;
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Entered just after a rising edge; bounded wait on pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         error_cnt++;
         stop_test();
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rd
   // Window of whole periods, so the phase does not matter
   task automatic sample(input int n);
      logic prev;
      prev = pin;
      hi = 0;
      rises = 0;
      repeat (n)
      begin
         @(posedge clk);
         hi += (pin === 1'b1);
         rises += (pin === 1'b1 && prev === 1'b0);
         prev = pin;
      end
   endtask : sample
   initial
   begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(TBPWM_OFF_TIMER_COUNT, 32'h0);
      rd(TBPWM_OFF_PERIOD, 32'hff);
      rd(TBPWM_OFF_TIMER_CTRL, 32'h0);
      rd(TBPWM_OFF_CHAN_CTRL, 32'h0);
      rd(TBPWM_OFF_FLAGS, 32'h0);
      rd(8'h1c, 32'h0);
      apb(1'b1, TBPWM_OFF_PERIOD, 32'h3);
      for (int p = 0; p < 3; p++)
      begin
         apb(1'b1, TBPWM_OFF_DUTY_LOW, 32'h2);
         apb(1'b1, TBPWM_OFF_TIMER_CTRL, {25'h0, 4'hf, 1'b1, pre[p]});
         apb(1'b1, TBPWM_OFF_CHAN_CTRL, 32'h2c);
         sample(32 * mul[p]);
         sample(32 * mul[p]);
         check(hi, 20 * mul[p]);
         check(rises, 2);
      end
      apb(1'b0, TBPWM_OFF_TIMER_COUNT, 32'h0);
      check(q <= 32'h3, 1);
      rd(TBPWM_OFF_DUTY_BUF, 32'h2);
      apb(1'b1, TBPWM_OFF_DUTY_BUF, 32'h99);
      rd(TBPWM_OFF_DUTY_BUF, 32'h2);
      // Write the new duty early in a period, so no restart falls before the read
      n = 0;
      do
      begin
         apb(1'b0, TBPWM_OFF_TIMER_COUNT, 32'h0);
         n++;
      end
      while (q !== 32'h0 && n < 200);
      if (q !== 32'h0)
      begin
         error_cnt++;
         stop_test();
      end
      apb(1'b1, TBPWM_OFF_DUTY_LOW, 32'h8);
      rd(TBPWM_OFF_DUTY_BUF, 32'h2);
      sample(512);
      sample(512);
      check(hi, 512);
      rd(TBPWM_OFF_DUTY_BUF, 32'h8);
      apb(1'b1, TBPWM_OFF_CHAN_CTRL, 32'h0);
      sample(8);
      sample(256);
      check(hi, 0);
      apb(1'b1, TBPWM_OFF_DUTY_LOW, 32'h0);
      apb(1'b1, TBPWM_OFF_CHAN_CTRL, 32'h0c);
      sample(512);
      sample(512);
      check(hi, 0);
      apb(1'b1, TBPWM_OFF_TIMER_CTRL, 32'h0);
      apb(1'b1, TBPWM_OFF_FLAGS, 32'h2);
      rd(TBPWM_OFF_FLAGS, 32'h0);
      apb(1'b1, TBPWM_OFF_TIMER_CTRL, 32'h4);
      sample(320);
      rd(TBPWM_OFF_FLAGS, 32'h2);
      stop_test();
   end
endmodule : testbench
